//--- half_flash_adc_conversion_sequencer_test.sv
// Purpose: Self-checking bench for the host sequencer
// Assumes: 50 ns clock; model timing in ns
// Notes: Input is changed after every start to prove hold
`timescale 1ns/1ps
`default_nettype none
module half_flash_adc_conversion_sequencer_test;
	logic clk, rst, req_valid, req_two_strobe, req_fast_read;
	logic req_ready, rsp_valid, rsp_overrange, rsp_timeout;
	logic device_select_n, read_strobe_n, mode_select, ws_o, ws_oe;
	logic pull_low, done_n, ovr_n, vin_over, mute;
	logic [7:0] rsp_data, bus, vin;
	tri1 start_pin;
	int error_cnt = 0;
	int comparisons = 0;
	int cycles = 0;
	realtime t_fall = 0;
	realtime t_rise = 0;
	realtime t_end = 0;
	// -----------------------------------------------------------
	// Structure
	// -----------------------------------------------------------
	// Shared pin: host drive or open-drain pull
	assign start_pin = ws_oe ? 1'bz : ws_o;
	assign start_pin = pull_low ? 1'b0 : 1'bz;
	hfa_host_seq dut (.clk(clk), .rst(rst), .req_valid(req_valid),
		.req_two_strobe(req_two_strobe), .req_fast_read(req_fast_read),
		.req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_data(rsp_data), .rsp_overrange(rsp_overrange),
		.rsp_timeout(rsp_timeout), .device_select_n(device_select_n),
		.read_strobe_n(read_strobe_n), .mode_select(mode_select),
		.write_start_n_o(ws_o), .write_start_n_oe(ws_oe),
		.wait_request_n_i(start_pin), .conversion_done_n(done_n),
		.overrange_n(ovr_n), .result_bus(bus));
	hfa_dev_model dev (.device_select_n(device_select_n),
		.read_strobe_n(read_strobe_n), .mode_select(mode_select),
		.start_pin(start_pin), .vin_code(vin), .vin_over(vin_over),
		.mute(mute), .pull_low(pull_low), .conversion_done_n(done_n),
		.overrange_n(ovr_n), .result_bus(bus));
	// -----------------------------------------------------------
	// Checking and timing monitors
	// -----------------------------------------------------------
	// Compare and count
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		comparisons++;
		if (seen !== exp) begin
			error_cnt++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check
	// Verdict and end of run
	task automatic print_verdict();
		if (error_cnt == 0 && comparisons > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : print_verdict
	always @(negedge start_pin) begin : mon_start
		realtime t_now;
		t_now = $realtime;
		#1;
		if (mode_select === 1'b1) begin
			t_fall = t_now;
			if (t_end > 0) check(8'(t_now - t_end >= 350), 8'h01);
		end
	end
	always @(posedge start_pin) if (mode_select === 1'b1) begin
		t_rise = $realtime;
		check(8'(t_rise - t_fall >= 250), 8'h01);
	end
	always @(negedge read_strobe_n) begin : mon_read
		realtime t_now;
		t_now = $realtime;
		#1;
		if (mode_select === 1'b0 && t_end > 0)
			check(8'(t_now - t_end >= 350), 8'h01);
		if (mode_select === 1'b1)
			check(8'(t_now - t_rise >= 250), 8'h01);
	end
	// End of each read access
	always @(posedge read_strobe_n) t_end = $realtime;
	// Clock and hang limit
	always #25 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 20000) begin
			error_cnt++;
			print_verdict();
		end
	end
	// -----------------------------------------------------------
	// Scenarios
	// -----------------------------------------------------------
	// One conversion request and wait for its answer
	task automatic do_conv(input logic two, input logic fast,
		input logic [7:0] code, input logic over, input logic quiet);
		int n;
		@(posedge clk);
		req_two_strobe <= two;
		req_fast_read <= fast;
		vin <= code;
		vin_over <= over;
		mute <= quiet;
		req_valid <= 1'b1;
		@(negedge clk);
		for (n = 0; n < 100 && req_ready !== 1'b1; n++) @(negedge clk);
		@(posedge clk);
		req_valid <= 1'b0;
		repeat (3) @(negedge clk);
		check({6'h0, mode_select, ws_oe}, {6'h0, two, !two});
		@(posedge clk);
		vin <= ~code;
		for (n = 0; n < 200 && rsp_valid !== 1'b1 && rsp_timeout !== 1'b1;
			n++) @(negedge clk);
		check(8'(n < 200), 8'h01);
	endtask : do_conv
	// Stretched reads back to back
	task automatic test_single();
		do_conv(1'b0, 1'b0, 8'hA5, 1'b0, 1'b0);
		check(rsp_data, 8'hA5);
		check({7'h0, rsp_overrange}, 8'h00);
		do_conv(1'b0, 1'b0, 8'hFF, 1'b1, 1'b0);
		check(rsp_data, 8'hFF);
		check({7'h0, rsp_overrange}, 8'h01);
	endtask : test_single
	// Start strobe, done flag, then read
	task automatic test_two_slow();
		do_conv(1'b1, 1'b0, 8'h3C, 1'b0, 1'b0);
		check(rsp_data, 8'h3C);
		check({7'h0, rsp_overrange}, 8'h00);
	endtask : test_two_slow
	// Read before done flag
	task automatic test_two_fast();
		do_conv(1'b1, 1'b1, 8'hC3, 1'b1, 1'b0);
		check(rsp_data, 8'hC3);
		check({7'h0, rsp_overrange}, 8'h01);
	endtask : test_two_fast
	// Device never finishes, then recovers
	task automatic test_timeout();
		do_conv(1'b0, 1'b0, 8'h5A, 1'b0, 1'b1);
		check({7'h0, rsp_timeout}, 8'h01);
		do_conv(1'b1, 1'b0, 8'h00, 1'b0, 1'b0);
		check({7'h0, rsp_timeout}, 8'h00);
		check(rsp_data, 8'h00);
	endtask : test_timeout
	// Main sequence
	initial begin
		clk = 1'b0;
		rst = 1'b1;
		req_valid = 1'b0;
		req_two_strobe = 1'b0;
		req_fast_read = 1'b0;
		vin = 8'h00;
		vin_over = 1'b0;
		mute = 1'b0;
		repeat (4) @(posedge clk);
		rst <= 1'b0;
		test_single();
		test_two_slow();
		test_two_fast();
		test_timeout();
		print_verdict();
	end
endmodule : half_flash_adc_conversion_sequencer_test
`default_nettype wire

//--- hfa_dev_model.sv
// Purpose: Behavioural half-flash converter facing the host sequencer
// Assumes: Times in ns; shared start/ready pin pulled up by the bench
// Notes: Bus shows inverted data whenever it is not being read
`timescale 1ns/1ps
`default_nettype none
module hfa_dev_model #(
	parameter int DONE_NS = 380,
	parameter int SINGLE_NS = 600
) (
	input wire logic device_select_n,
	input wire logic read_strobe_n,
	input wire logic mode_select,
	input wire logic start_pin,
	input wire logic [7:0] vin_code,
	input wire logic vin_over,
	input wire logic mute,
	output logic pull_low,
	output logic conversion_done_n,
	output logic overrange_n,
	output logic [7:0] result_bus
);
	logic [7:0] held = 8'h00;
	logic over_s = 1'b0;
	logic armed = 1'b0;
	logic ready = 1'b0;
	// -----------------------------------------------------------
	// Conversion phases
	// -----------------------------------------------------------
	initial begin
		pull_low = 1'b0;
		conversion_done_n = 1'b1;
		overrange_n = 1'b1;
	end
	task automatic finish_conv();
		conversion_done_n = 1'b0;
		overrange_n = ~over_s;
		ready = 1'b1;
		armed = 1'b0;
	endtask : finish_conv
	task automatic take_sample();
		held = vin_code;
		over_s = vin_over;
		ready = 1'b0;
		overrange_n = 1'b1;
	endtask : take_sample
	// start on write fall, two-strobe only
	// Settle step: select and mode move in the same step as the pin
	always @(negedge start_pin) begin
		#1;
		if (mode_select && !device_select_n && !start_pin) take_sample();
	end
	// lower nibble, then done after delay
	always @(posedge start_pin) begin
		if (mode_select && !device_select_n) begin
			armed = 1'b1;
			#(DONE_NS);
			if (armed && !mute) finish_conv();
		end
	end
	// read fall: fast latch or single start
	always @(negedge read_strobe_n) begin
		#1;
		if (!device_select_n && mode_select && armed) begin
			finish_conv();
		end else if (!device_select_n && !mode_select) begin
			take_sample();
			pull_low = 1'b1;
			#(SINGLE_NS);
			if (!mute) begin
				finish_conv();
				pull_low = 1'b0;
			end
		end
	end
	always @(posedge read_strobe_n or posedge device_select_n) begin
		conversion_done_n = 1'b1;
		pull_low = 1'b0;
	end
	assign result_bus = (ready && !device_select_n && !read_strobe_n) ?
		held : ~held;
endmodule : hfa_dev_model
`default_nettype wire

//--- hfa_host_seq.sv
// Purpose: Host-side sequencer driving a half-flash 8-bit converter
// Assumes: 20 MHz clock; device pins asynchronous; pull-up on wait pin
// Notes: Pin inputs pass two flops before any logic reads them
`timescale 1ns/1ps
`default_nettype none
module hfa_host_seq (
	input wire logic clk,
	input wire logic rst,
	input wire logic req_valid,
	input wire logic req_two_strobe,
	input wire logic req_fast_read,
	output logic req_ready,
	output logic rsp_valid,
	output logic [7:0] rsp_data,
	output logic rsp_overrange,
	output logic rsp_timeout,
	output logic device_select_n,
	output logic read_strobe_n,
	output logic mode_select,
	output logic write_start_n_o,
	output logic write_start_n_oe,
	input wire logic wait_request_n_i,
	input wire logic conversion_done_n,
	input wire logic overrange_n,
	input wire logic [7:0] result_bus
);
	// ------------------------------------------------------------
	// Declarations
	// ------------------------------------------------------------
	hfa_sync_if sy ();
	hfa_pkg::hfa_state_type state_q;
	logic [hfa_pkg::CNT_W-1:0] cnt_q;
	logic two_q;
	logic fast_q;
	logic cs_n_q;
	logic rd_n_q;
	logic wr_n_q;
	logic mode_q;
	logic [7:0] data_q;
	logic ovr_q;
	logic vld_q;
	logic to_q;
	logic done_seen;

	hfa_pin_sync u_sync (
		.clk(clk),
		.rst(rst),
		.pins({overrange_n, wait_request_n_i, conversion_done_n,
			result_bus}),
		.so(sy.src)
	);

	// Completion: done flag low, and in single mode the wait pin released as well
	assign done_seen = two_q ? !sy.done_n : (sy.wait_n && !sy.done_n);

	// ------------------------------------------------------------
	// Sequencer state and timing counter
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_q <= hfa_pkg::ST_RECOVER;
			cnt_q <= '0;
			two_q <= 1'b0;
			fast_q <= 1'b0;
		end else begin
			case (state_q)
				hfa_pkg::ST_IDLE: begin
					if (req_valid) begin
						two_q <= req_two_strobe;
						fast_q <= req_fast_read;
						cnt_q <= '0;
						state_q <= req_two_strobe ? hfa_pkg::ST_START
							: hfa_pkg::ST_WAIT;
					end
				end
				hfa_pkg::ST_START: begin
					// start strobe held its least width
					if (cnt_q == hfa_pkg::CNT_W'(hfa_pkg::START_LOW_CYC - 1)) begin
						cnt_q <= '0;
						state_q <= hfa_pkg::ST_GAPRD;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				hfa_pkg::ST_GAPRD: begin
					// fast read after least start-to-read delay
					if (fast_q && cnt_q ==
						hfa_pkg::CNT_W'(hfa_pkg::START_TO_READ_CYC - 1)) begin
						cnt_q <= '0;
						state_q <= hfa_pkg::ST_ACCESS;
					end else if (!fast_q && done_seen) begin
						// wait for done flag before reading
						cnt_q <= '0;
						state_q <= hfa_pkg::ST_ACCESS;
					end else if (cnt_q ==
						hfa_pkg::CNT_W'(hfa_pkg::DONE_TIMEOUT_CYC)) begin
						cnt_q <= '0;
						state_q <= hfa_pkg::ST_ACCESS;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				hfa_pkg::ST_WAIT: begin
					if (done_seen || cnt_q ==
						hfa_pkg::CNT_W'(hfa_pkg::DONE_TIMEOUT_CYC)) begin
						cnt_q <= '0;
						state_q <= hfa_pkg::ST_ACCESS;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				hfa_pkg::ST_ACCESS: begin
					if (cnt_q == hfa_pkg::CNT_W'(hfa_pkg::ACCESS_CYC)) begin
						cnt_q <= '0;
						state_q <= hfa_pkg::ST_RECOVER;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				hfa_pkg::ST_RECOVER: begin
					// recovery gap before next starting edge
					if (cnt_q == hfa_pkg::CNT_W'(hfa_pkg::RECOVERY_CYC - 1)) begin
						cnt_q <= '0;
						state_q <= hfa_pkg::ST_IDLE;
					end else begin
						cnt_q <= cnt_q + 1'b1;
					end
				end
				default: begin
					state_q <= hfa_pkg::ST_RECOVER;
					cnt_q <= '0;
				end
			endcase
		end
	end

	// ------------------------------------------------------------
	// Strobe pins
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cs_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			mode_q <= 1'b0;
		end else begin
			cs_n_q <= 1'b1;
			rd_n_q <= 1'b1;
			wr_n_q <= 1'b1;
			if (state_q == hfa_pkg::ST_IDLE && req_valid) begin
				// mode pin set with the start
				mode_q <= req_two_strobe;
				cs_n_q <= 1'b0;
				// falling edge of start or read samples
				wr_n_q <= !req_two_strobe;
				rd_n_q <= req_two_strobe;
			end else if (state_q == hfa_pkg::ST_START) begin
				cs_n_q <= 1'b0;
				// rising start edge at end of pulse
				wr_n_q <= (cnt_q ==
					hfa_pkg::CNT_W'(hfa_pkg::START_LOW_CYC - 1));
			end else if (state_q == hfa_pkg::ST_GAPRD) begin
				cs_n_q <= 1'b1;
			end else if (state_q == hfa_pkg::ST_WAIT) begin
				cs_n_q <= 1'b0;
				rd_n_q <= 1'b0;
			end else if (state_q == hfa_pkg::ST_ACCESS) begin
				// select and read low for data
				cs_n_q <= (cnt_q == hfa_pkg::CNT_W'(hfa_pkg::ACCESS_CYC));
				rd_n_q <= (cnt_q == hfa_pkg::CNT_W'(hfa_pkg::ACCESS_CYC));
			end
		end
	end

	// ------------------------------------------------------------
	// Result capture
	// ------------------------------------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			data_q <= hfa_pkg::RESULT_RST;
			ovr_q <= 1'b0;
			vld_q <= 1'b0;
			to_q <= 1'b0;
		end else begin
			vld_q <= 1'b0;
			if ((state_q == hfa_pkg::ST_GAPRD || state_q == hfa_pkg::ST_WAIT)
				&& cnt_q == hfa_pkg::CNT_W'(hfa_pkg::DONE_TIMEOUT_CYC)
				&& !(fast_q && state_q == hfa_pkg::ST_GAPRD)) begin
				to_q <= !done_seen;
			end else if (state_q == hfa_pkg::ST_IDLE && req_valid) begin
				to_q <= 1'b0;
			end
			if (state_q == hfa_pkg::ST_ACCESS &&
				cnt_q == hfa_pkg::CNT_W'(hfa_pkg::ACCESS_CYC)) begin
				// upper nibble in bits 7:4, lower in 3:0
				// code taken as the device presents it
				data_q <= sy.data;
				ovr_q <= !sy.ovr_n;
				vld_q <= 1'b1;
			end
		end
	end

	// ------------------------------------------------------------
	// Outputs
	// ------------------------------------------------------------
	assign req_ready = (state_q == hfa_pkg::ST_IDLE);
	assign rsp_valid = vld_q;
	assign rsp_data = data_q;
	assign rsp_overrange = ovr_q;
	assign rsp_timeout = to_q;
	assign device_select_n = cs_n_q;
	assign read_strobe_n = rd_n_q;
	assign mode_select = mode_q;
	assign write_start_n_o = wr_n_q;
	// shared pin driven only in two-strobe mode
	assign write_start_n_oe = !mode_q;

	// ------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------
	a_start_width: assert property (@(posedge clk) disable iff (rst)
		$fell(wr_n_q) |-> !wr_n_q [*5])
		else $error("start strobe too short");
	a_gap_before: assert property (@(posedge clk) disable iff (rst)
		$rose(cs_n_q) && state_q == hfa_pkg::ST_RECOVER
		|-> cs_n_q [*7])
		else $error("recovery gap violated");
	a_fast_read: assert property (@(posedge clk) disable iff (rst)
		$rose(wr_n_q) && fast_q |-> rd_n_q [*5])
		else $error("read too early after start");
	a_single_pin: assert property (@(posedge clk) disable iff (rst)
		!mode_q && !cs_n_q |-> write_start_n_oe && wr_n_q)
		else $error("shared pin driven in single mode");
	a_read_select: assert property (@(posedge clk) disable iff (rst)
		!rd_n_q |-> !cs_n_q)
		else $error("read without select");
	a_mode_pin: assert property (@(posedge clk) disable iff (rst)
		!wr_n_q |-> mode_q)
		else $error("start strobe in single mode");
	a_start_sample: assert property (@(posedge clk) disable iff (rst)
		req_valid && req_ready |=> !cs_n_q && (!wr_n_q || !rd_n_q))
		else $error("no starting edge");
	a_rsp_end: assert property (@(posedge clk) disable iff (rst)
		rsp_valid |-> rd_n_q && cs_n_q)
		else $error("strobes not released at result");
	c_single: cover property (@(posedge clk) disable iff (rst)
		rsp_valid && !mode_q);
	c_two_slow: cover property (@(posedge clk) disable iff (rst)
		rsp_valid && mode_q && !fast_q);
	c_two_fast: cover property (@(posedge clk) disable iff (rst)
		rsp_valid && fast_q);
endmodule : hfa_host_seq
`default_nettype wire

//--- hfa_pin_sync.sv
// Purpose: Two-flop synchronisers for all device outputs
// Assumes: Pins are asynchronous to clk
// Notes: First stage is read only by the second stage
`timescale 1ns/1ps
`default_nettype none
module hfa_pin_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic [10:0] pins,
	hfa_sync_if.src so
);
	logic [10:0] meta_q;
	logic [10:0] sync_q;
	genvar i;
	// ------------------------------------------------------------
	// Per-bit two-stage chain; idle levels are high for strobes
	// ------------------------------------------------------------
	generate
		for (i = 0; i < 11; i++) begin : g_bit
			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					meta_q[i] <= 1'b1;
					sync_q[i] <= 1'b1;
				end else begin
					meta_q[i] <= pins[i];
					sync_q[i] <= meta_q[i];
				end
			end
		end
	endgenerate
	assign so.data = sync_q[7:0];
	assign so.done_n = sync_q[8];
	assign so.wait_n = sync_q[9];
	assign so.ovr_n = sync_q[10];
endmodule : hfa_pin_sync
`default_nettype wire

//--- hfa_pkg.sv
// Purpose: Shared constants for the half-flash converter host sequencer
// Assumes: 20 MHz system clock, 50 ns period
// Notes: Time figures in ns; cycle counts derived here
package hfa_pkg;
	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 50;
	localparam int RECOVERY_GAP_NS = 350;
	localparam int START_LOW_NS = 250;
	localparam int START_TO_READ_NS = 250;
	localparam int INTERNAL_TIMEOUT_DELAY_NS = 380;
	localparam int ACCESS_NS = 160;
	// Least times round up
	localparam int RECOVERY_CYC =
		(RECOVERY_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int START_LOW_CYC =
		(START_LOW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int START_TO_READ_CYC =
		(START_TO_READ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACCESS_CYC =
		(ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Give-up bound while waiting for completion flags
	localparam int DONE_TIMEOUT_CYC =
		4 * ((INTERNAL_TIMEOUT_DELAY_NS + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS);
	localparam int CNT_W = 8;
	// ------------------------------------------------------------
	// Data layout
	// ------------------------------------------------------------
	localparam int RESULT_W = 8;
	localparam int NIBBLE_W = 4;
	localparam logic [7:0] RESULT_RST = 8'h00;
	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_START = 3'b001,
		ST_GAPRD = 3'b010,
		ST_WAIT = 3'b011,
		ST_ACCESS = 3'b100,
		ST_RECOVER = 3'b101
	} hfa_state_type;
endpackage : hfa_pkg

//--- hfa_sync_if.sv
// Purpose: Carrier of synchronised device pin levels
// Assumes: Single clock domain
// Notes: Driven by the synchroniser, read by the sequencer
`timescale 1ns/1ps
`default_nettype none
interface hfa_sync_if;
	logic done_n;
	logic wait_n;
	logic ovr_n;
	logic [7:0] data;
	modport src (output done_n, output wait_n, output ovr_n, output data);
	modport dst (input done_n, input wait_n, input ovr_n, input data);
endinterface : hfa_sync_if
`default_nettype wire
